/* File: rpd_top.sv */
/*
  Rotor position detector with an APB register slave. Samples three
  position inputs, compares them with an expected pattern or with the
  pattern seen at start or at the last detection, and pulses a detection event after a programmed
  number of consecutive hits.
  Assumes all inputs are synchronous to pclk and that the sampling delay
  after a PWM or lower-phase turn-on is already applied upstream.
*/
`timescale 1ns/1ps
`default_nettype none
module rpd_top
  import rpd_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Position inputs and their port direction masks.
  input wire logic u_phase_input,
  input wire logic v_phase_input,
  input wire logic w_phase_input,
  input wire logic [2:0] pin_output_mask,
  // Expected pattern, bit 2 W, bit 1 V, bit 0 U.
  input wire logic [2:0] expected_pattern,
  // PWM and conduction status.
  input wire logic pwm_active_period,
  input wire logic [2:0] lower_phase_conducting,
  // Timer triggers.
  input wire logic timer_start_trigger,
  input wire logic timer_stop_trigger,
  // Detection outputs.
  output logic detection_signal,
  output logic detection_interrupt,
  output logic sampling_active
);

  //////////////////////////////////////////////////////////////////////////
  // Register decode.

  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
    reg_decode = {a == ADDR_STAT, a == ADDR_SCFG, a == ADDR_CTRL};
  endfunction

  logic [2:0] wr_dec;
  logic [2:0] rd_dec;
  logic access;
  logic wr_en;
  logic rd_setup;

  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_dec = reg_decode(paddr);
  assign rd_dec = reg_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = access && (wr_dec == 3'b000);

  //////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic [7:0] ctrl_r;
  logic [7:0] scfg_r;
  logic ctrl_wr;
  logic sw_start;
  logic sw_stop;

  assign ctrl_wr = wr_en && wr_dec[0];
  assign sw_start = ctrl_wr && pwdata[CTL_SW_START];
  assign sw_stop = ctrl_wr && pwdata[CTL_SW_STOP];

  // The two command bits are strobes and are not stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= {2'b00, pwdata[CTL_TSTOP_EN:CTL_EN]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scfg_r <= SCFG_RST;
    end else if (wr_en && wr_dec[1]) begin
      scfg_r <= pwdata[7:0];
    end
  end

  logic enable;
  logic dmode;
  logic recount;
  logic pin1;
  logic [1:0] smode;
  logic [1:0] per_sel;
  logic [CNT_W-1:0] hit_target;

  assign enable = ctrl_r[CTL_EN];
  assign dmode = ctrl_r[CTL_DMODE];
  assign recount = ctrl_r[CTL_RECOUNT];
  assign pin1 = ctrl_r[CTL_PIN1];
  assign smode = scfg_r[SCF_MODE_HI:SCF_MODE_LO];
  assign per_sel = scfg_r[SCF_PER_HI:SCF_PER_LO];
  assign hit_target = CNT_W'(scfg_r[SCF_CNT_HI:SCF_CNT_LO]);

  //////////////////////////////////////////////////////////////////////////
  // Start and stop requests.

  logic start_req;
  logic stop_req;

  // Configuration changes are expected only while enable is low.
  assign start_req = enable && (sw_start ||
                     (ctrl_r[CTL_TSTART_EN] && timer_start_trigger));
  assign stop_req = sw_stop ||
                    (ctrl_r[CTL_TSTOP_EN] && timer_stop_trigger);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer.

  rpd_state_e state_r;
  rpd_state_e state_nxt;
  logic running;
  logic done;

  assign running = (state_r != ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (done && !dmode) begin
          state_nxt = ST_IDLE;
        end else if (stop_req) begin
          state_nxt = ST_STOPPING;
        end
      end
      ST_STOPPING: begin
        // Sampling goes on until the next detection ends it.
        if (done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!enable) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sampling.

  logic tick;
  logic [2:0] pos_in;
  logic [2:0] gate;
  logic [2:0] samp_r;
  logic [2:0] samp_now;
  logic sample;
  logic pwm_prev_r;
  logic pwm_fall;

  // Pins turned to outputs read as zero.
  assign pos_in = {w_phase_input, v_phase_input, u_phase_input} & ~pin_output_mask;
  assign pwm_fall = pwm_prev_r && !pwm_active_period;

  rpd_sample_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .period_sel(per_sel),
    .tick(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      always_comb begin
        case (smode)
          SMODE_PWM: gate[gi] = pwm_active_period;
          SMODE_REG: gate[gi] = 1'b1;
          SMODE_LOW: gate[gi] = lower_phase_conducting[gi];
          default: gate[gi] = 1'b0;
        endcase
      end
      // An idle phase keeps its last sample for the comparison.
      assign samp_now[gi] = gate[gi] ? pos_in[gi] : samp_r[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          samp_r[gi] <= 1'b0;
        end else if (start_req && !running) begin
          samp_r[gi] <= pos_in[gi];
        end else if (sample) begin
          samp_r[gi] <= samp_now[gi];
        end
      end
    end
  endgenerate

  assign sample = running && tick && (gate != 3'b000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_prev_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_active_period;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Comparison.

  logic [2:0] cmp_mask;
  logic [2:0] ref_r;
  logic equal;
  logic differ;
  logic armed_r;
  logic hit;
  logic cnt_clear;

  assign cmp_mask = pin1 ? 3'b001 : 3'b111;
  assign equal = ((samp_now ^ expected_pattern) & cmp_mask) == 3'b000;
  assign differ = ((samp_now ^ ref_r) & cmp_mask) != 3'b000;
  assign hit = dmode ? differ : (equal && armed_r);

  // Start status of the inputs, reloaded on each change-mode detection, W in bit 2 and U in bit 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= CAP_RST;
    end else if (start_req && !running) begin
      ref_r <= pos_in;
    end else if (done && dmode) begin
      ref_r <= samp_now;
    end
  end

  // A match counts only after a mismatch has been seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (!running || (start_req && !running)) begin
      armed_r <= 1'b0;
    end else if (sample && !equal) begin
      armed_r <= 1'b1;
    end
  end

  // Recount is tied to PWM-on sampling only; otherwise hits run on.
  assign cnt_clear = !running ||
                     (recount && (smode == SMODE_PWM) && pwm_fall);

  rpd_hit_counter #(
    .CNT_W(CNT_W)
  ) u_hits (
    .pclk(pclk),
    .presetn(presetn),
    .clear(cnt_clear),
    .sample(sample),
    .hit(hit),
    .target(hit_target),
    .done(done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Edge result and outputs.

  logic fall_seen_r;
  logic [1:0] edge_r;
  logic det_r;

  // Tracks whether the current run of hits crossed a PWM falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_seen_r <= 1'b0;
    end else if (!running || (sample && !hit) || done) begin
      fall_seen_r <= 1'b0;
    end else if (pwm_fall) begin
      fall_seen_r <= 1'b1;
    end
  end

  // Updated only by a detection, so software reads it afterwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_r <= EDGE_RST;
    end else if (done && running) begin
      edge_r <= {fall_seen_r, !pwm_active_period};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_r <= 1'b0;
    end else begin
      det_r <= done && running;
    end
  end

  assign detection_signal = det_r;
  assign detection_interrupt = det_r;
  assign sampling_active = running;

  //////////////////////////////////////////////////////////////////////////
  // Read data, latched in the setup phase.

  logic [7:0] stat_val;
  logic [7:0] rd_val;

  assign stat_val = {2'b00, edge_r, running, ref_r};

  always_comb begin
    case (rd_dec)
      3'b001: rd_val = ctrl_r;
      3'b010: rd_val = scfg_r;
      3'b100: rd_val = stat_val;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end
endmodule
`default_nettype wire

/* File: rpd_pkg.sv */
/*
  Constants for the rotor position detector: register map, field positions,
  reset values, field encodings and the sequencer states.
  Assumes nothing; every design file of the block except rpd_hit_counter imports it.
*/
`default_nettype none
package rpd_pkg;
  localparam int ADDR_W = 16;
  // Printed offsets are register indexes; byte address is four times each.
  localparam logic [15:0] IDX_CTRL = 16'h1FA0;
  localparam logic [15:0] IDX_SCFG = 16'h1FA1;
  localparam logic [15:0] IDX_STAT = 16'h1FA2;
  localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};
  localparam logic [15:0] ADDR_SCFG = {IDX_SCFG[13:0], 2'b00};
  localparam logic [15:0] ADDR_STAT = {IDX_STAT[13:0], 2'b00};
  // Control register fields.
  localparam int CTL_SW_STOP = 7;
  localparam int CTL_SW_START = 6;
  localparam int CTL_TSTOP_EN = 5;
  localparam int CTL_TSTART_EN = 4;
  localparam int CTL_PIN1 = 3;
  localparam int CTL_RECOUNT = 2;
  localparam int CTL_DMODE = 1;
  localparam int CTL_EN = 0;
  // Sampling configuration fields.
  localparam int SCF_PER_HI = 7;
  localparam int SCF_PER_LO = 6;
  localparam int SCF_MODE_HI = 5;
  localparam int SCF_MODE_LO = 4;
  localparam int SCF_CNT_HI = 3;
  localparam int SCF_CNT_LO = 0;
  // Status fields.
  localparam int STA_EDGE_HI = 5;
  localparam int STA_EDGE_LO = 4;
  localparam int STA_MON = 3;
  localparam int STA_CAP_HI = 2;
  localparam int STA_CAP_LO = 0;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SCFG_RST = 8'h00;
  localparam logic [2:0] CAP_RST = 3'h0;
  localparam logic [1:0] EDGE_RST = 2'h0;
  // Sampling mode codes.
  localparam logic [1:0] SMODE_PWM = 2'b00;
  localparam logic [1:0] SMODE_REG = 2'b01;
  localparam logic [1:0] SMODE_LOW = 2'b10;
  // Edge result codes.
  localparam logic [1:0] EDGE_CUR = 2'b00;
  localparam logic [1:0] EDGE_OFF = 2'b01;
  localparam logic [1:0] EDGE_CUR_FALL = 2'b10;
  localparam logic [1:0] EDGE_PREV = 2'b11;
  // Smallest sampling divider is two to this power.
  localparam int DIV_SHIFT_MIN = 2;
  localparam int DIV_W = 5;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_STOPPING} rpd_state_e;
endpackage
`default_nettype wire

/* File: rpd_sample_tick.sv */
/*
  Sampling strobe generator: one pulse every 4, 8, 16 or 32 clocks.
  Assumes the period select is stable while the strobe runs.
*/
`timescale 1ns/1ps
`default_nettype none
module rpd_sample_tick
  import rpd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic run,
  input wire logic [1:0] period_sel,
  // Strobe.
  output logic tick
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask = DIV_W'((32'd1 << (32'(period_sel) + DIV_SHIFT_MIN)) - 32'd1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + DIV_W'(1);
    end
  end

  assign tick = run && ((cnt_r & mask) == mask);
endmodule
`default_nettype wire

/* File: rpd_hit_counter.sv */
/*
  Consecutive hit counter: counts qualifying samples in a row and pulses
  done when the programmed count is reached.
  Assumes sample is a one-cycle strobe and clear has priority.
*/
`timescale 1ns/1ps
`default_nettype none
module rpd_hit_counter #(
  parameter int CNT_W = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic clear,
  input wire logic sample,
  input wire logic hit,
  input wire logic [CNT_W-1:0] target,
  // Result.
  output logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] goal;

  // A zero target behaves as one hit.
  assign goal = (target == '0) ? CNT_W'(1) : target;
  assign done = sample && hit && ((cnt_r + CNT_W'(1)) >= goal);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clear || (sample && (!hit || done))) begin
      cnt_r <= '0;
    end else if (sample) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

/* File: rpd_top_chk.sv */
/*
  Port checker for the rotor position detector.
  Assumes it is bound into rpd_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rpd_top_chk
  import rpd_pkg::*;
(
  // Bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Detection.
  input wire logic timer_start_trigger,
  input wire logic detection_signal,
  input wire logic detection_interrupt,
  input wire logic sampling_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  logic start_req;
  logic off_req;
  assign acc = psel && penable;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_SCFG) || (paddr == ADDR_STAT);
  assign start_req = (acc && pwrite && paddr == ADDR_CTRL && pwdata[CTL_SW_START])
    || timer_start_trigger;
  assign off_req = acc && pwrite && paddr == ADDR_CTRL && !pwdata[CTL_EN];
  sequence s_pulse;
    detection_signal ##1 !detection_signal;
  endsequence
  sequence s_quiet_start;
    !detection_signal [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_irq_with_det: assert property (detection_interrupt == detection_signal)
    else $error("interrupt and detection differ");
  a_det_pulse: assert property (detection_signal |-> s_pulse)
    else $error("detection longer than one cycle");
  a_det_needs_run: assert property (detection_signal |-> $past(sampling_active))
    else $error("detection while sampling idle");
  a_start_cause: assert property ($rose(sampling_active) |-> $past(start_req))
    else $error("sampling began without a start");
  a_first_strobe: assert property ($rose(sampling_active) |-> s_quiet_start)
    else $error("detection before the first strobe");
  a_stop_cause: assert property ($fell(sampling_active) |->
    detection_signal || $past(off_req) || $past(off_req, 2))
    else $error("sampling ended without cause");
  a_monitor_read: assert property (acc && !pwrite && paddr == ADDR_STAT |->
    prdata[STA_MON] == $past(sampling_active))
    else $error("monitor bit wrong");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("error response wrong");
endmodule
bind rpd_top rpd_top_chk rpd_top_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .timer_start_trigger, .detection_signal, .detection_interrupt,
  .sampling_active);
`default_nettype wire

/* File: rpd_pos_model.sv */
/*
  Far-side model: the three position comparators, PWM state and lower-side conduction.
  Assumes the bench names the wanted levels; outputs follow one clock later.
*/
`timescale 1ns/1ps
`default_nettype none
module rpd_pos_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Wanted levels, bit 2 W, bit 0 U.
  input wire logic [2:0] want_pattern,
  input wire logic want_pwm,
  // Motor side.
  output logic u_phase_input,
  output logic v_phase_input,
  output logic w_phase_input,
  output logic pwm_active_period,
  output logic [2:0] lower_phase_conducting
);
  // Levels move only on an edge, as they would behind a synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {w_phase_input, v_phase_input, u_phase_input} <= 3'h0;
      pwm_active_period <= 1'b0;
    end else begin
      {w_phase_input, v_phase_input, u_phase_input} <= want_pattern;
      pwm_active_period <= want_pwm;
    end
  end
  // The lower side conducts while the PWM is off.
  assign lower_phase_conducting = {3{~pwm_active_period}};
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking bench for rpd_top over APB with the position model.
  Assumes the zero-wait APB slave and register map of rpd_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rpd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [ADDR_W-1:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, u_phase_input, v_phase_input, w_phase_input, pwm_active_period;
  logic [2:0] lower_phase_conducting, want = 3'h0, pin_output_mask = 3'h0, expected_pattern = 3'h0;
  logic want_pwm = 1'b1, timer_start_trigger = 1'b0, timer_stop_trigger = 1'b0;
  logic detection_signal, detection_interrupt, sampling_active;
  logic [ADDR_W-1:0] addrs[4] = '{ADDR_CTRL, ADDR_SCFG, ADDR_STAT, 16'h7E8C};
  int err_total = 0, checks_done = 0, cyc = 0, lat;
  always #50 pclk = ~pclk;
  rpd_pos_model rpd_pos_model_i (.pclk, .presetn, .want_pattern(want), .want_pwm,
    .u_phase_input, .v_phase_input, .w_phase_input, .pwm_active_period, .lower_phase_conducting);
  rpd_top rpd_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .u_phase_input, .v_phase_input, .w_phase_input, .pin_output_mask,
    .expected_pattern, .pwm_active_period, .lower_phase_conducting, .timer_start_trigger,
    .timer_stop_trigger, .detection_signal, .detection_interrupt, .sampling_active);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge pclk);
      chk("no_detection", 0, {31'h0, detection_signal});
    end
  endtask
  task automatic wait_det(input int lim, output int t);
    t = 0;
    while (detection_signal !== 1'b1 && t < lim) begin
      @(negedge pclk);
      t++;
    end
  endtask
  // Ordinary run: matching at start must stay silent; a mismatch arms the compare.
  task automatic run_ord(input logic [1:0] per, md, input logic [3:0] cnt, input logic pin1,
      input logic [2:0] ex, mt);
    int p, n, t;
    p = 4 << per;
    n = (cnt == 4'h0) ? 1 : int'(cnt);
    expected_pattern <= ex;
    want <= mt;
    want_pwm <= (md != SMODE_LOW);
    apb(1'b1, ADDR_SCFG, {per, md, cnt});
    apb(1'b0, ADDR_SCFG, 8'h00);
    chk("scfg_readback", {24'h00_0000, per, md, cnt}, rd);
    apb(1'b1, ADDR_CTRL, {4'h0, pin1, 3'h1});
    apb(1'b1, ADDR_CTRL, {4'h4, pin1, 3'h1});
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("monitor_busy", 1, {31'h0, rd[STA_MON]});
    quiet(2 * n * p + 8);
    want <= ~mt;
    quiet(2 * p + 2);
    want <= mt;
    if (md == SMODE_PWM) begin
      want_pwm <= 1'b0;
      quiet(3 * p);
      want_pwm <= 1'b1;
    end
    wait_det(n * p + 8, t);
    chk("latency_ok", 1, {31'h0, t >= (n - 1) * p && t <= n * p + 3});
    @(negedge pclk);
    chk("stopped", 0, {31'h0, sampling_active});
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("monitor_idle", 0, {31'h0, rd[STA_MON]});
    chk("edge_result", {31'h0, md == SMODE_LOW}, {31'h0, rd[STA_EDGE_LO]});
    apb(1'b1, ADDR_CTRL, 8'h00);
    $display("ordinary run period %0d count %0d done", p, n);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 8'h00);
      chk("reset_value", 0, rd);
    end
    chk("unmapped_err", 1, {31'h0, err});
    apb(1'b1, ADDR_STAT, 8'h3F);
    apb(1'b1, ADDR_CTRL, 8'hFE);
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("status_read_only", 0, rd);
    apb(1'b0, ADDR_CTRL, 8'h00);
    chk("ctrl_readback", 32'h0000_003E, rd);
    apb(1'b1, ADDR_CTRL, 8'h00);
    $display("register test done");
    run_ord(2'h0, SMODE_REG, 4'h0, 1'b0, 3'h5, 3'h5);
    run_ord(2'h1, SMODE_REG, 4'h3, 1'b0, 3'h2, 3'h2);
    run_ord(2'h2, SMODE_PWM, 4'h2, 1'b0, 3'h4, 3'h4);
    run_ord(2'h3, SMODE_REG, 4'h1, 1'b0, 3'h6, 3'h6);
    run_ord(2'h0, SMODE_LOW, 4'h2, 1'b1, 3'h1, 3'h7);
    pin_output_mask <= 3'h6;
    run_ord(2'h0, SMODE_REG, 4'h1, 1'b0, 3'h1, 3'h7);
    pin_output_mask <= 3'h0;
    // Recount: a four-cycle PWM pulse holds one sample, so two hits never gather.
    expected_pattern <= 3'h4;
    want <= 3'h3;
    apb(1'b1, ADDR_SCFG, 8'h02);
    apb(1'b1, ADDR_CTRL, 8'h05);
    apb(1'b1, ADDR_CTRL, 8'h45);
    quiet(12);
    want <= 3'h4;
    repeat (6) begin
      want_pwm <= 1'b0;
      quiet(4);
      want_pwm <= 1'b1;
      quiet(4);
    end
    wait_det(12, lat);
    chk("recount_det", 1, {31'h0, lat <= 8});
    apb(1'b1, ADDR_CTRL, 8'h00);
    $display("recount test done");
    // Change mode: timer start; without a stop a change detects and sampling runs on.
    want <= 3'h6;
    apb(1'b1, ADDR_SCFG, 8'h12);
    apb(1'b1, ADDR_CTRL, 8'h33);
    @(posedge pclk) timer_start_trigger <= 1'b1;
    @(posedge pclk) timer_start_trigger <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("timer_start", 1, {31'h0, sampling_active});
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("start_capture", 32'h0000_000E, {28'h000_0000, rd[3:0]});
    quiet(16);
    want <= 3'h7;
    wait_det(20, lat);
    chk("change_latency_ok", 1, {31'h0, lat >= 4 && lat <= 11});
    @(negedge pclk);
    chk("change_runs_on", 1, {31'h0, sampling_active});
    @(posedge pclk) timer_stop_trigger <= 1'b1;
    @(posedge pclk) timer_stop_trigger <= 1'b0;
    quiet(16);
    want <= 3'h6;
    wait_det(20, lat);
    @(negedge pclk);
    chk("timer_stopped", 0, {31'h0, sampling_active});
    // Software start, then a software stop ends it at the next change.
    apb(1'b1, ADDR_CTRL, 8'h00);
    apb(1'b1, ADDR_CTRL, 8'h03);
    apb(1'b1, ADDR_CTRL, 8'h43);
    apb(1'b1, ADDR_CTRL, 8'h83);
    quiet(16);
    want <= 3'h7;
    wait_det(20, lat);
    chk("soft_stop_latency_ok", 1, {31'h0, lat >= 4 && lat <= 11});
    @(negedge pclk);
    chk("change_stopped", 0, {31'h0, sampling_active});
    apb(1'b1, ADDR_CTRL, 8'h00);
    apb(1'b1, ADDR_CTRL, 8'h40);
    repeat (4) @(negedge pclk);
    chk("disabled_idle", 0, {31'h0, sampling_active});
    $display("change and disable tests done");
    close_out();
  end
endmodule
`default_nettype wire
